// [logic/srb_exec.sv]
// Purpose: Executes stack store/load, bit clear, returns and interrupt return
// Assumes: Asynchronous memory read, data valid while MEM_RD is high
// Notes: Unlisted unprefixed opcodes run as three-state no-ops
// Behaviour
// - Loading a pair keeps flags unless the pair is accumulator-flags.
// - Load reads low byte at stack pointer, high at next, then adds two.
// - Store decrements, writes high byte, decrements again, writes low byte.
// - Store changes no flags and never checks for stack overflow.
// - Pair select 00 first, 01 second, 10 memory pointer, 11 accumulator-flags.
// - Store takes accumulator-flags, general pairs, or index X/Y via DD/FD E5.
// - Index store takes 14 states, single-byte pair store 11 states.
// - Bit clear zeroes the chosen bit, keeps others and all flags.
// - Bit number 0 selects least significant bit, 7 the most significant.
// - Bit clear works on register, pointer byte or index plus displacement.
// - Register field 000 B to 101 L and 111 A.
// - Bit clear takes 7, 12 or 19 states by operand kind.
// - Return loads counter low from stack, high from next, stack plus two.
// - False conditional return leaves stack alone and goes to next opcode.
// - Condition field tests zero, carry, parity, sign, clear then set.
// - ED then 4D is recognised as the interrupt return.
`timescale 1ns/1ps
`include "srb_map.svh"
module srb_exec (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] MEM_RDATA,
   output logic [15:0] MEM_ADDR,
   output logic [7:0] MEM_WDATA,
   output logic MEM_RD,
   output logic MEM_WR,
   output logic [15:0] REG_PC,
   output logic [15:0] REG_SP,
   output logic [15:0] REG_AF,
   output logic [15:0] REG_BC,
   output logic [15:0] REG_DE,
   output logic [15:0] REG_HL,
   output logic [15:0] REG_IX,
   output logic [15:0] REG_IY,
   output logic INSTR_DONE,
   output logic INTERRUPT_RETURN_SEEN
);
   // ====================================================================
   // State
   srb_pkg::srb_state_t state, next_state;
   srb_pkg::srb_pop_dest_t pop_dest, next_pop_dest;
   srb_pkg::srb_kind_t kind, next_kind;
   logic [15:0] pc, sp, ix, iy, next_pc, next_sp, next_ix, next_iy;
   logic [7:0] a, f, b, c, d, e, h, l;
   logic [7:0] next_a, next_f, next_b, next_c, next_d, next_e, next_h, next_l;
   logic [15:0] next_mem_addr;
   logic [7:0] next_mem_wdata, tcount, next_tcount, ttarget, next_ttarget;
   logic [7:0] disp, next_disp, tmp_lo, next_tmp_lo;
   logic next_mem_rd, next_mem_wr, next_done, next_interrupt_return;
   logic [1:0] pfx_idx, next_pfx_idx;
   logic pfx_cb, next_pfx_cb, pfx_ed, next_pfx_ed, got_disp, next_got_disp;
   logic [2:0] bit_sel, next_bit_sel;
   logic [7:0] opc, clr_val;
   logic [15:0] idx_val, idx_addr, push_val;
   logic do_push;

   // ====================================================================
   // Decoders
   // register field
   function automatic logic [7:0] reg_get(input logic [2:0] code, input logic [7:0] rb,
      input logic [7:0] rc, input logic [7:0] rd, input logic [7:0] re,
      input logic [7:0] rh, input logic [7:0] rl, input logic [7:0] ra);
      unique case (code)
         3'h0: reg_get = rb;
         3'h1: reg_get = rc;
         3'h2: reg_get = rd;
         3'h3: reg_get = re;
         3'h4: reg_get = rh;
         3'h5: reg_get = rl;
         3'h7: reg_get = ra;
         default: reg_get = 8'h00;
      endcase
   endfunction

   function automatic logic cond_true(input logic [2:0] cc, input logic [7:0] fl);
      unique case (cc[2:1])
         2'h0: cond_true = fl[`SRB_F_Z] == cc[0];
         2'h1: cond_true = fl[`SRB_F_C] == cc[0];
         2'h2: cond_true = fl[`SRB_F_PV] == cc[0];
         default: cond_true = fl[`SRB_F_S] == cc[0];
      endcase
   endfunction

   function automatic logic [7:0] clr_bit(input logic [7:0] v, input logic [2:0] n);
      clr_bit = v & ~(8'h01 << n);
   endfunction

   // ====================================================================
   // Next-state logic
   always_comb begin
      next_state = state;
      next_pop_dest = pop_dest;
      next_kind = kind;
      next_pc = pc;
      next_sp = sp;
      next_ix = ix;
      next_iy = iy;
      next_a = a;
      next_f = f;
      next_b = b;
      next_c = c;
      next_d = d;
      next_e = e;
      next_h = h;
      next_l = l;
      next_mem_rd = 1'b0;
      next_mem_wr = 1'b0;
      next_mem_addr = MEM_ADDR;
      next_mem_wdata = MEM_WDATA;
      next_tcount = 8'(tcount + 8'h01);
      next_ttarget = ttarget;
      next_disp = disp;
      next_tmp_lo = tmp_lo;
      next_pfx_idx = pfx_idx;
      next_pfx_cb = pfx_cb;
      next_pfx_ed = pfx_ed;
      next_got_disp = got_disp;
      next_bit_sel = bit_sel;
      next_done = 1'b0;
      next_interrupt_return = 1'b0;
      do_push = 1'b0;
      push_val = 16'h0000;
      opc = MEM_RDATA;
      idx_val = (pfx_idx == 2'h1) ? ix : iy;
      idx_addr = 16'(idx_val + {{8{disp[7]}}, disp});
      clr_val = clr_bit(reg_get(opc[2:0], b, c, d, e, h, l, a), opc[5:3]);
      unique case (state)
         srb_pkg::SRB_ST_FETCH: begin
            next_mem_rd = 1'b1;
            next_mem_addr = pc;
            next_pc = 16'(pc + 16'h0001);
            next_state = srb_pkg::SRB_ST_OPC;
         end
         srb_pkg::SRB_ST_OPC: begin
            next_state = srb_pkg::SRB_ST_WAIT;
            next_kind = srb_pkg::SRB_K_OTHER;
            next_ttarget = `SRB_T_OTHER;
            if (pfx_ed) begin
               if (opc == `SRB_OP_INTERRUPT_RETURN_2) begin
                  next_interrupt_return = 1'b1;
                  next_kind = srb_pkg::SRB_K_INTERRUPT_RETURN;
                  next_ttarget = `SRB_T_INTERRUPT_RETURN;
                  next_pop_dest = srb_pkg::SRB_PD_PC;
                  next_state = srb_pkg::SRB_ST_POP_LO;
               end
            end else if (pfx_cb && pfx_idx != 2'h0 && !got_disp) begin
               next_disp = opc;
               next_got_disp = 1'b1;
               next_state = srb_pkg::SRB_ST_FETCH;
            end else if (pfx_cb) begin
               if (opc[7:6] == `SRB_CB_CLR) begin
                  next_bit_sel = opc[5:3];
                  if (pfx_idx != 2'h0) begin
                     next_mem_rd = 1'b1;
                     next_mem_addr = idx_addr;
                     next_kind = srb_pkg::SRB_K_CLR_IDX;
                     next_ttarget = `SRB_T_CLR_IDX;
                     next_state = srb_pkg::SRB_ST_RMW;
                  end else if (opc[2:0] == `SRB_MEM_OPND) begin
                     next_mem_rd = 1'b1;
                     next_mem_addr = {h, l};
                     next_kind = srb_pkg::SRB_K_CLR_HL;
                     next_ttarget = `SRB_T_CLR_HL;
                     next_state = srb_pkg::SRB_ST_RMW;
                  end else begin
                     next_kind = srb_pkg::SRB_K_CLR_REG;
                     next_ttarget = `SRB_T_CLR_REG;
                     unique case (opc[2:0])
                        3'h0: next_b = clr_val;
                        3'h1: next_c = clr_val;
                        3'h2: next_d = clr_val;
                        3'h3: next_e = clr_val;
                        3'h4: next_h = clr_val;
                        3'h5: next_l = clr_val;
                        default: next_a = clr_val;
                     endcase
                  end
               end
            end else if (opc == `SRB_OP_PFX_X || opc == `SRB_OP_PFX_Y) begin
               next_pfx_idx = (opc == `SRB_OP_PFX_X) ? 2'h1 : 2'h2;
               next_state = srb_pkg::SRB_ST_FETCH;
            end else if (opc == `SRB_OP_PFX_CB || opc == `SRB_OP_PFX_ED) begin
               next_pfx_cb = (opc == `SRB_OP_PFX_CB);
               next_pfx_ed = (opc == `SRB_OP_PFX_ED);
               next_state = srb_pkg::SRB_ST_FETCH;
            end else if (pfx_idx != 2'h0) begin
               if (opc == `SRB_OP_PUSH_IDX) begin
                  do_push = 1'b1;
                  push_val = idx_val;
                  next_kind = srb_pkg::SRB_K_PUSH_IDX;
                  next_ttarget = `SRB_T_PUSH_IDX;
               end else if (opc == `SRB_OP_POP_IDX) begin
                  next_kind = srb_pkg::SRB_K_POP_IDX;
                  next_ttarget = `SRB_T_POP_IDX;
                  next_pop_dest = (pfx_idx == 2'h1) ? srb_pkg::SRB_PD_IX : srb_pkg::SRB_PD_IY;
                  next_state = srb_pkg::SRB_ST_POP_LO;
               end
            end else if (opc[7:6] == 2'h3 && opc[3:0] == 4'h5) begin
               do_push = 1'b1;
               next_kind = srb_pkg::SRB_K_PUSH_QQ;
               next_ttarget = `SRB_T_PUSH_QQ;
               unique case (opc[5:4])
                  2'h0: push_val = {b, c};
                  2'h1: push_val = {d, e};
                  2'h2: push_val = {h, l};
                  default: push_val = {a, f};
               endcase
            end else if (opc[7:6] == 2'h3 && opc[3:0] == 4'h1) begin
               next_kind = srb_pkg::SRB_K_POP_QQ;
               next_ttarget = `SRB_T_POP_QQ;
               next_pop_dest = srb_pkg::srb_pop_dest_t'({1'b0, opc[5:4]});
               next_state = srb_pkg::SRB_ST_POP_LO;
            end else if (opc == `SRB_OP_RET) begin
               next_kind = srb_pkg::SRB_K_RET;
               next_ttarget = `SRB_T_RET;
               next_pop_dest = srb_pkg::SRB_PD_PC;
               next_state = srb_pkg::SRB_ST_POP_LO;
            end else if (opc[7:6] == 2'h3 && opc[2:0] == 3'h0) begin
               if (cond_true(opc[5:3], f)) begin
                  next_kind = srb_pkg::SRB_K_RETC_TRUE;
                  next_ttarget = `SRB_T_RETC_TRUE;
                  next_pop_dest = srb_pkg::SRB_PD_PC;
                  next_state = srb_pkg::SRB_ST_POP_LO;
               end else begin
                  next_kind = srb_pkg::SRB_K_RETC_FALSE;
                  next_ttarget = `SRB_T_RETC_FALSE;
               end
            end
            // first byte read at stack pointer
            if (next_state == srb_pkg::SRB_ST_POP_LO) begin
               next_mem_rd = 1'b1;
               next_mem_addr = sp;
               next_sp = 16'(sp + 16'h0001);
            end
            if (do_push) begin
               next_mem_wr = 1'b1;
               next_sp = 16'(sp - 16'h0001);
               next_mem_addr = 16'(sp - 16'h0001);
               next_mem_wdata = push_val[15:8];
               next_tmp_lo = push_val[7:0];
               next_state = srb_pkg::SRB_ST_PUSH_LO;
            end
         end
         srb_pkg::SRB_ST_POP_LO: begin
            next_tmp_lo = MEM_RDATA;
            next_mem_rd = 1'b1;
            next_mem_addr = sp;
            next_sp = 16'(sp + 16'h0001);
            next_state = srb_pkg::SRB_ST_POP_HI;
         end
         srb_pkg::SRB_ST_POP_HI: begin
            unique case (pop_dest)
               srb_pkg::SRB_PD_BC: {next_b, next_c} = {MEM_RDATA, tmp_lo};
               srb_pkg::SRB_PD_DE: {next_d, next_e} = {MEM_RDATA, tmp_lo};
               srb_pkg::SRB_PD_HL: {next_h, next_l} = {MEM_RDATA, tmp_lo};
               srb_pkg::SRB_PD_AF: {next_a, next_f} = {MEM_RDATA, tmp_lo};
               srb_pkg::SRB_PD_IX: next_ix = {MEM_RDATA, tmp_lo};
               srb_pkg::SRB_PD_IY: next_iy = {MEM_RDATA, tmp_lo};
               default: next_pc = {MEM_RDATA, tmp_lo};
            endcase
            next_state = srb_pkg::SRB_ST_WAIT;
         end
         srb_pkg::SRB_ST_PUSH_LO: begin
            next_mem_wr = 1'b1;
            next_sp = 16'(sp - 16'h0001);
            next_mem_addr = 16'(sp - 16'h0001);
            next_mem_wdata = tmp_lo;
            next_state = srb_pkg::SRB_ST_WAIT;
         end
         srb_pkg::SRB_ST_RMW: begin
            next_mem_wr = 1'b1;
            next_mem_wdata = clr_bit(MEM_RDATA, bit_sel);
            next_state = srb_pkg::SRB_ST_WAIT;
         end
         srb_pkg::SRB_ST_WAIT: begin
            // pad to the documented state count
            if (tcount >= 8'(ttarget - 8'h01)) begin
               next_done = 1'b1;
               next_tcount = 8'h00;
               next_pfx_idx = 2'h0;
               next_pfx_cb = 1'b0;
               next_pfx_ed = 1'b0;
               next_got_disp = 1'b0;
               next_state = srb_pkg::SRB_ST_FETCH;
            end
         end
         default: next_state = srb_pkg::SRB_ST_FETCH;
      endcase
   end

   // ====================================================================
   // Registers
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state <= srb_pkg::SRB_ST_FETCH;
         pop_dest <= srb_pkg::SRB_PD_PC;
         kind <= srb_pkg::SRB_K_OTHER;
         {pc, sp, ix, iy, MEM_ADDR} <= {5{`SRB_RST_WORD}};
         {a, f, b, c, d, e, h, l} <= {8{`SRB_RST_BYTE}};
         {MEM_WDATA, tcount, ttarget, disp, tmp_lo} <= {5{`SRB_RST_BYTE}};
         {MEM_RD, MEM_WR, INSTR_DONE, INTERRUPT_RETURN_SEEN} <= 4'h0;
         {pfx_idx, pfx_cb, pfx_ed, got_disp, bit_sel} <= 8'h00;
      end else begin
         state <= next_state;
         pop_dest <= next_pop_dest;
         kind <= next_kind;
         {pc, sp, ix, iy, MEM_ADDR} <= {next_pc, next_sp, next_ix, next_iy, next_mem_addr};
         {a, f, b, c} <= {next_a, next_f, next_b, next_c};
         {d, e, h, l} <= {next_d, next_e, next_h, next_l};
         {MEM_WDATA, tcount, ttarget} <= {next_mem_wdata, next_tcount, next_ttarget};
         {disp, tmp_lo} <= {next_disp, next_tmp_lo};
         {MEM_RD, MEM_WR, INSTR_DONE, INTERRUPT_RETURN_SEEN} <= {next_mem_rd, next_mem_wr, next_done, next_interrupt_return};
         {pfx_idx, pfx_cb, pfx_ed} <= {next_pfx_idx, next_pfx_cb, next_pfx_ed};
         {got_disp, bit_sel} <= {next_got_disp, next_bit_sel};
      end
   end

   assign REG_PC = pc;
   assign REG_SP = sp;
   assign REG_AF = {a, f};
   assign REG_BC = {b, c};
   assign REG_DE = {d, e};
   assign REG_HL = {h, l};
   assign REG_IX = ix;
   assign REG_IY = iy;

   // ====================================================================
   // Assertions
   default clocking cb_clk @(posedge CLK); endclocking
   default disable iff (RST);

   sequence push_high_s;
      MEM_WR && state == srb_pkg::SRB_ST_PUSH_LO;
   endsequence
   sequence push_low_s;
      MEM_WR && MEM_ADDR == 16'($past(MEM_ADDR) - 16'h0001) && MEM_WDATA == $past(tmp_lo);
   endsequence

   pop_flags_a: assert property ((state == srb_pkg::SRB_ST_POP_HI && pop_dest != srb_pkg::SRB_PD_AF) |=> $stable(f)) else $error("flags changed on pair load");
   pop_order_a: assert property (state == srb_pkg::SRB_ST_POP_HI |-> MEM_RD && MEM_ADDR == 16'($past(MEM_ADDR) + 16'h0001) && sp == 16'(MEM_ADDR + 16'h0001)) else $error("load address order wrong");
   push_order_a: assert property (push_high_s |=> push_low_s ##0 (sp == MEM_ADDR)) else $error("store order wrong");
   push_flags_a: assert property (push_high_s |=> $stable(f) ##1 $stable(f)) else $error("flags changed on store");
   push_idx_time_a: assert property ((INSTR_DONE && kind == srb_pkg::SRB_K_PUSH_IDX) |-> $past(tcount) == 8'(`SRB_T_PUSH_IDX - 8'h01)) else $error("index store length wrong");
   clr_value_a: assert property (state == srb_pkg::SRB_ST_RMW |=> MEM_WR && MEM_WDATA == ($past(MEM_RDATA) & ~(8'h01 << $past(bit_sel))) && $stable(f)) else $error("bit clear value wrong");
   clr_idx_time_a: assert property ((INSTR_DONE && kind == srb_pkg::SRB_K_CLR_IDX) |-> $past(tcount) == 8'(`SRB_T_CLR_IDX - 8'h01)) else $error("indexed clear length wrong");
   ret_pc_a: assert property ((state == srb_pkg::SRB_ST_POP_HI && pop_dest == srb_pkg::SRB_PD_PC) |=> pc == {$past(MEM_RDATA), $past(tmp_lo)}) else $error("return address wrong");
   retc_false_a: assert property ((INSTR_DONE && kind == srb_pkg::SRB_K_RETC_FALSE) |-> $past(tcount) == 8'(`SRB_T_RETC_FALSE - 8'h01) && $stable(sp)) else $error("false return wrong");
   interrupt_return_seen_a: assert property (INTERRUPT_RETURN_SEEN |-> $past(MEM_RDATA) == `SRB_OP_INTERRUPT_RETURN_2 ##[1:2] (state == srb_pkg::SRB_ST_POP_HI && pop_dest == srb_pkg::SRB_PD_PC)) else $error("interrupt return not run");
endmodule

// [logic/srb_map.svh]
// Purpose: Constants for the stack, bit-clear and return executor
// Assumes: One clock state per CLK cycle
// Notes: Opcode values, flag positions and state totals
`ifndef SRB_MAP_SVH
`define SRB_MAP_SVH
// ====================================================================
// Opcodes and prefixes
`define SRB_OP_PFX_X 8'hdd
`define SRB_OP_PFX_Y 8'hfd
`define SRB_OP_PFX_CB 8'hcb
`define SRB_OP_PFX_ED 8'hed
`define SRB_OP_PUSH_IDX 8'he5
`define SRB_OP_POP_IDX 8'he1
`define SRB_OP_RET 8'hc9
`define SRB_OP_INTERRUPT_RETURN_2 8'h4d
`define SRB_CB_CLR 2'h2
`define SRB_MEM_OPND 3'h6
// ====================================================================
// Flag bit positions
`define SRB_F_S 7
`define SRB_F_Z 6
`define SRB_F_PV 2
`define SRB_F_C 0
// ====================================================================
// Instruction totals in clock states; one state is one cycle
`define SRB_T_PUSH_QQ 8'h0b
`define SRB_T_PUSH_IDX 8'h0e
`define SRB_T_POP_QQ 8'h09
`define SRB_T_POP_IDX 8'h0c
`define SRB_T_CLR_REG 8'h07
`define SRB_T_CLR_HL 8'h0c
`define SRB_T_CLR_IDX 8'h13
`define SRB_T_RET 8'h09
`define SRB_T_RETC_TRUE 8'h0a
`define SRB_T_RETC_FALSE 8'h05
`define SRB_T_INTERRUPT_RETURN 8'h16
`define SRB_T_OTHER 8'h03
// ====================================================================
// Reset values
`define SRB_RST_WORD 16'h0000
`define SRB_RST_BYTE 8'h00
`endif

// [logic/srb_pkg.sv]
// Purpose: Types for the stack, bit-clear and return executor
// Assumes: Nothing beyond the map header
// Notes: States, pop destinations and instruction kinds
package srb_pkg;
   typedef enum logic [2:0] {
      SRB_ST_FETCH = 3'h0,
      SRB_ST_OPC = 3'h1,
      SRB_ST_POP_LO = 3'h2,
      SRB_ST_POP_HI = 3'h3,
      SRB_ST_PUSH_LO = 3'h4,
      SRB_ST_RMW = 3'h5,
      SRB_ST_WAIT = 3'h6
   } srb_state_t;
   typedef enum logic [2:0] {
      SRB_PD_BC = 3'h0,
      SRB_PD_DE = 3'h1,
      SRB_PD_HL = 3'h2,
      SRB_PD_AF = 3'h3,
      SRB_PD_IX = 3'h4,
      SRB_PD_IY = 3'h5,
      SRB_PD_PC = 3'h6
   } srb_pop_dest_t;
   typedef enum logic [3:0] {
      SRB_K_OTHER = 4'h0,
      SRB_K_PUSH_QQ = 4'h1,
      SRB_K_PUSH_IDX = 4'h2,
      SRB_K_POP_QQ = 4'h3,
      SRB_K_POP_IDX = 4'h4,
      SRB_K_CLR_REG = 4'h5,
      SRB_K_CLR_HL = 4'h6,
      SRB_K_CLR_IDX = 4'h7,
      SRB_K_RET = 4'h8,
      SRB_K_RETC_TRUE = 4'h9,
      SRB_K_RETC_FALSE = 4'ha,
      SRB_K_INTERRUPT_RETURN = 4'hb
   } srb_kind_t;
endpackage

// [verification/srb_mem_model.sv]
// Purpose: Memory holding program and stack for the executor
// Assumes: Reads answer in the same cycle, writes land at the clock edge
// Notes: Between reads the data lines show the inverse of the last byte read
`timescale 1ns/1ps
module srb_mem_model (
   input wire logic clk,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_rd,
   input wire logic mem_wr,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last;
   // ====================
   // Storage and bus
   initial begin
      last = 8'h00;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h00;
      end
   end
   // Released lines must not keep a stale byte the core could wrongly use
   assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
   always @(posedge clk) begin
      if (mem_rd) begin
         last <= mem[mem_addr];
      end
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule

// [verification/test_stack_return_bitclear_exec.sv]
// Purpose: Self-checking bench for the stack, bit-clear and return executor
// Assumes: Registers are final when the next fetch shows INSTR_DONE
// Notes: One program runs through all scenarios in order
`timescale 1ns/1ps
module test_stack_return_bitclear_exec;
   logic CLK, RST, MEM_RD, MEM_WR, INSTR_DONE, INTERRUPT_RETURN_SEEN;
   logic [7:0] MEM_RDATA, MEM_WDATA;
   logic [15:0] MEM_ADDR, REG_PC, REG_SP, REG_AF, REG_BC, REG_DE, REG_HL, REG_IX, REG_IY;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int interrupt_return_cnt = 0;
   srb_exec srb_exec_i (.CLK(CLK), .RST(RST), .MEM_RDATA(MEM_RDATA), .MEM_ADDR(MEM_ADDR),
      .MEM_WDATA(MEM_WDATA), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .REG_PC(REG_PC),
      .REG_SP(REG_SP), .REG_AF(REG_AF), .REG_BC(REG_BC), .REG_DE(REG_DE), .REG_HL(REG_HL),
      .REG_IX(REG_IX), .REG_IY(REG_IY), .INSTR_DONE(INSTR_DONE), .INTERRUPT_RETURN_SEEN(INTERRUPT_RETURN_SEEN));
   srb_mem_model srb_mem_model_i (.clk(CLK), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA),
      .mem_rd(MEM_RD), .mem_wr(MEM_WR), .mem_rdata(MEM_RDATA));
   // ====================
   // Clock and watchdog
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (INTERRUPT_RETURN_SEEN === 1'b1) begin
         interrupt_return_cnt <= interrupt_return_cnt + 1;
      end
      if (cyc == 3000) begin
         $display("timeout after %0d cycles", cyc);
         n_mismatch++;
         end_of_test();
      end
   end
   // ====================
   // Shared tasks
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic put(input logic [15:0] a, input logic [7:0] b [$]);
      foreach (b[i]) begin
         srb_mem_model_i.mem[a + 16'(i)] = b[i];
      end
   endtask
   // Counts cycles up to the next instruction boundary
   task automatic step(input int len);
      int n;
      n = 0;
      do begin
         @(posedge CLK);
         #1;
         n++;
      end while (INSTR_DONE !== 1'b1 && n < 40);
      chk("instruction length", 16'(len), 16'(n));
   endtask
   // ====================
   // Scenarios
   task automatic t_wrap();
      step(11);
      chk("sp after store at zero", 16'hfffe, REG_SP);
      chk("wrapped store bytes", 16'h0000, {srb_mem_model_i.mem[16'hffff],
         srb_mem_model_i.mem[16'hfffe]});
      step(9);
      chk("sp after load wrap", 16'h0000, REG_SP);
      step(9);
      chk("pc after return", 16'hc1c5, REG_PC);
      chk("sp after return", 16'h0002, REG_SP);
   endtask
   task automatic t_pop();
      step(9);
      chk("af load", 16'ha0c9, REG_AF);
      step(9);
      chk("bc load", 16'h1234, REG_BC);
      chk("flags kept", 16'ha0c9, REG_AF);
      step(9);
      chk("de load", 16'h5678, REG_DE);
      step(9);
      chk("hl load", 16'h9abc, REG_HL);
      step(12);
      chk("ix load", 16'h3000, REG_IX);
      step(12);
      chk("iy load", 16'h3080, REG_IY);
      chk("sp after loads", 16'h000e, REG_SP);
   endtask
   task automatic t_push();
      logic [7:0] exp [12] = '{8'h80, 8'h30, 8'h00, 8'h30, 8'hc9, 8'ha0, 8'hbc, 8'h9a,
         8'h78, 8'h56, 8'h34, 8'h12};
      for (int i = 0; i < 4; i++) begin
         step(11);
      end
      step(14);
      step(14);
      chk("sp after stores", 16'h0002, REG_SP);
      chk("flags after stores", 16'ha0c9, REG_AF);
      for (int i = 0; i < 12; i++) begin
         chk("stacked byte", 16'(exp[i]), 16'(srb_mem_model_i.mem[2 + i]));
      end
   endtask
   task automatic t_clear();
      for (int i = 0; i < 7; i++) begin
         step(7);
      end
      chk("bc cleared", 16'h1030, REG_BC);
      chk("de cleared", 16'h4658, REG_DE);
      chk("hl cleared", 16'h1ab8, REG_HL);
      chk("af cleared", 16'h80c9, REG_AF);
      step(12);
      chk("pointer byte", 16'h00fe, 16'(srb_mem_model_i.mem[16'h1ab8]));
      step(19);
      chk("x indexed byte", 16'h00f7, 16'(srb_mem_model_i.mem[16'h3005]));
      step(19);
      chk("y indexed byte", 16'h00bf, 16'(srb_mem_model_i.mem[16'h307e]));
   endtask
   task automatic t_return();
      for (int i = 0; i < 4; i++) begin
         step(5);
      end
      chk("pc after false returns", 16'hc1f1, REG_PC);
      chk("sp after false returns", 16'h0002, REG_SP);
      step(10);
      chk("pc zero set", 16'h3080, REG_PC);
      step(10);
      chk("pc carry set", 16'h3000, REG_PC);
      step(10);
      chk("pc parity odd", 16'ha0c9, REG_PC);
      step(10);
      chk("pc sign set", 16'h9abc, REG_PC);
      step(9);
      chk("pc plain return", 16'h5678, REG_PC);
      chk("no early interrupt return", 16'h0000, 16'(interrupt_return_cnt));
      step(22);
      chk("pc interrupt return", 16'h1234, REG_PC);
      chk("sp interrupt return", 16'h000e, REG_SP);
      chk("interrupt return seen", 16'h0001, 16'(interrupt_return_cnt));
   endtask
   // ====================
   // Main sequence
   initial begin
      RST = 1'b1;
      #1;
      put(16'h0000, '{8'hc5, 8'hc1, 8'hc9, 8'ha0, 8'h34, 8'h12, 8'h78, 8'h56, 8'hbc, 8'h9a,
         8'h00, 8'h30, 8'h80, 8'h30});
      put(16'hfffe, '{8'h55, 8'h55});
      put(16'hc1c5, '{8'hf1, 8'hc1, 8'hd1, 8'he1, 8'hdd, 8'he1, 8'hfd, 8'he1, 8'hc5, 8'hd5,
         8'he5, 8'hf5, 8'hdd, 8'he5, 8'hfd, 8'he5, 8'hcb, 8'h88, 8'hcb, 8'h91, 8'hcb, 8'ha2,
         8'hcb, 8'hab, 8'hcb, 8'hbc, 8'hcb, 8'h95, 8'hcb, 8'haf, 8'hcb, 8'h86, 8'hdd, 8'hcb,
         8'h05, 8'h9e, 8'hfd, 8'hcb, 8'hfe, 8'hb6, 8'hc0, 8'hd0, 8'he8, 8'hf0, 8'hc8});
      put(16'h3080, '{8'hd8, 8'h00});
      put(16'h3000, '{8'he0, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff});
      put(16'h307e, '{8'hff});
      put(16'h1ab8, '{8'hff});
      put(16'ha0c9, '{8'hf8});
      put(16'h9abc, '{8'hc9});
      put(16'h5678, '{8'hed, 8'h4d});
      repeat (4) @(posedge CLK);
      #1;
      RST = 1'b0;
      t_wrap();
      t_pop();
      t_push();
      t_clear();
      t_return();
      end_of_test();
   end
endmodule
